// File: hdl/activity_detect_jack_status_regs.sv
/*
 * Jack status and low-power activity detect / signal generation register slice.
 * Holds the read-only jack flags, the writable detect, generator and clock
 * configuration, and the ADC power sequencer that acts on them.
 * Assumes an 8-bit register port from the control interface, synchronous to i_clk,
 * with a one-cycle write strobe and read data valid one cycle after the address.
 */
`timescale 1ns/1ps
`include "activity_detect_cfg.svh"
module activity_detect_jack_status_regs
	import activity_detect_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_write,
	output logic [7:0] o_reg_rdata,
	// jack detection result
	input wire logic i_detect_done,
	input wire logic [1:0] i_jack_condition,
	input wire logic [1:0] i_headset_variant,
	// activity detector and user commands
	input wire logic i_activity_event,
	input wire logic i_user_power_up,
	input wire logic i_user_power_down,
	// serial data output pin
	input wire logic i_serial_data_output,
	output logic o_serial_data_output,
	// decoded controls
	output logic o_adc_power_on,
	output logic o_detector_active,
	output logic [1:0] o_monitor_channel,
	output logic [1:0] o_generator_channel,
	output logic [1:0] o_activity_clock_source,
	output logic [1:0] o_external_clock_rate
);
	logic [1:0] jack_condition_reg;
	logic [1:0] headset_variant_reg;
	logic [7:0] activity_cfg_reg;
	logic [7:0] signal_gen_reg;
	logic [7:0] clock_cfg_reg;
	logic [7:0] rdata_next;
	logic [7:0] status_word;
	logic wr_activity_cfg;
	logic wr_signal_gen;
	logic wr_clock_cfg;
	logic pin_irq_mode;
	logic [1:0] monitor_field;
	logic [1:0] generator_field;
	logic [1:0] clock_source_field;
	logic [1:0] clock_rate_field;
	activity_detect_if cfg_bus ();

	// write decode; the status register and unmapped addresses get no strobe,
	// so a stray write there cannot disturb any stored bit
	assign wr_activity_cfg = i_reg_write && (i_reg_addr == `ADDR_ACTIVITY_DETECT_CONFIG);
	assign wr_signal_gen = i_reg_write && (i_reg_addr == `ADDR_SIGNAL_GEN_CONFIG);
	assign wr_clock_cfg = i_reg_write && (i_reg_addr == `ADDR_DETECT_GEN_CLOCK_CONFIG);

	// jack condition changes only on a final detection, register writes ignored;
	// a half-settled comparator result never reaches software this way
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			jack_condition_reg <= `RST_JACK_CONDITION;
		end else if (i_detect_done) begin
			jack_condition_reg <= i_jack_condition;
		end
	end

	// headset variant follows the same final-result strobe
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			headset_variant_reg <= `RST_HEADSET_VARIANT;
		end else if (i_detect_done) begin
			headset_variant_reg <= i_headset_variant;
		end
	end

	// activity configuration; reserved bits 2 and 0 masked so they read zero
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			activity_cfg_reg <= `RST_ACTIVITY_DETECT_CONFIG;
		end else if (wr_activity_cfg) begin
			activity_cfg_reg <= i_reg_wdata & `MASK_ACTIVITY_DETECT_CONFIG;
		end
	end

	// generator configuration; only the channel field is stored
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			signal_gen_reg <= `RST_SIGNAL_GEN_CONFIG;
		end else if (wr_signal_gen) begin
			signal_gen_reg <= i_reg_wdata & `MASK_SIGNAL_GEN_CONFIG;
		end
	end

	// shared clock configuration; bit 3 and bits 1-0 masked to zero
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			clock_cfg_reg <= `RST_DETECT_GEN_CLOCK_CONFIG;
		end else if (wr_clock_cfg) begin
			clock_cfg_reg <= i_reg_wdata & `MASK_DETECT_GEN_CLOCK_CONFIG;
		end
	end

	// status word; the reserved low nibble is tied to zero whatever the host wrote
	assign status_word = {jack_condition_reg, headset_variant_reg, 4'h0};

	// read mux; unmapped addresses read zero so a probe of the gap is harmless
	always_comb begin
		case (i_reg_addr)
			`ADDR_JACK_HEADSET_STATUS:
				rdata_next = status_word;
			`ADDR_ACTIVITY_DETECT_CONFIG: rdata_next = activity_cfg_reg;
			`ADDR_SIGNAL_GEN_CONFIG: rdata_next = signal_gen_reg;
			`ADDR_DETECT_GEN_CLOCK_CONFIG: rdata_next = clock_cfg_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// read data answers one cycle after the address edge, while the address stands
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_reg_rdata <= 8'h00;
		end else begin
			o_reg_rdata <= rdata_next;
		end
	end

	// field slices for the output copies
	assign monitor_field = activity_cfg_reg[`POS_MONITOR_CHANNEL +: 2];
	assign generator_field = signal_gen_reg[`POS_GENERATOR_CHANNEL +: 2];
	assign clock_source_field = clock_cfg_reg[`POS_ACTIVITY_CLOCK_SOURCE +: 2];
	assign clock_rate_field = clock_cfg_reg[`POS_EXTERNAL_CLOCK_RATE +: 2];

	// field decode toward the policy unit; code 3 of the policy field is passed
	// on unchanged and the sequencer treats it as user-only control
	assign cfg_bus.policy = adc_power_policy_t'(activity_cfg_reg[`POS_ADC_POWER_POLICY +: 2]);
	assign cfg_bus.irq_enable = activity_cfg_reg[`POS_DATA_OUT_IRQ_ENABLE];
	assign cfg_bus.detect_while_recording = activity_cfg_reg[`POS_DETECT_WHILE_RECORDING];
	assign cfg_bus.phase_one_enable = clock_cfg_reg[`POS_PHASE_ONE_ENABLE];

	// power sequencer and interrupt level, fed through the carrier interface
	adc_power_policy_unit u_policy (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_activity_event(i_activity_event),
		.i_user_power_up(i_user_power_up),
		.i_user_power_down(i_user_power_down),
		.cfg(cfg_bus.policy_unit)
	);

	// pin carries the interrupt only when enabled and not recording, otherwise
	// recorded serial data passes through; registered so the pin cannot glitch
	// while the power state changes
	assign pin_irq_mode = cfg_bus.irq_enable && !cfg_bus.adc_on;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_serial_data_output <= 1'b0;
		end else if (pin_irq_mode) begin
			o_serial_data_output <= cfg_bus.data_out_irq;
		end else begin
			o_serial_data_output <= i_serial_data_output;
		end
	end

	// power and detector status copies, one cycle behind the sequencer
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_adc_power_on <= 1'b0;
			o_detector_active <= 1'b0;
		end else begin
			o_adc_power_on <= cfg_bus.adc_on;
			o_detector_active <= cfg_bus.detector_active;
		end
	end

	// channel selects; detector and generator read these, not the registers
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_monitor_channel <= `RST_MONITOR_CHANNEL;
			o_generator_channel <= `RST_GENERATOR_CHANNEL;
		end else begin
			o_monitor_channel <= monitor_field;
			o_generator_channel <= generator_field;
		end
	end

	// clock configuration copies; a change lands two edges after the write,
	// so the clock switch downstream must tolerate that lag
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_activity_clock_source <= `RST_ACTIVITY_CLOCK_SOURCE;
			o_external_clock_rate <= `RST_EXTERNAL_CLOCK_RATE;
		end else begin
			o_activity_clock_source <= clock_source_field;
			o_external_clock_rate <= clock_rate_field;
		end
	end
endmodule

// File: hdl/activity_detect_cfg.svh
/*
 * Register map constants for the jack status and activity-detect register slice.
 * Assumes an 8-bit register port addressed by the codec's control interface.
 */
`ifndef ACTIVITY_DETECT_CFG_SVH
`define ACTIVITY_DETECT_CFG_SVH

`define ADDR_JACK_HEADSET_STATUS 8'h1c
`define ADDR_ACTIVITY_DETECT_CONFIG 8'h1e
`define ADDR_SIGNAL_GEN_CONFIG 8'h1f
`define ADDR_DETECT_GEN_CLOCK_CONFIG 8'h20

`define RST_JACK_HEADSET_STATUS 8'h00
`define RST_ACTIVITY_DETECT_CONFIG 8'h20
`define RST_SIGNAL_GEN_CONFIG 8'h80
`define RST_DETECT_GEN_CLOCK_CONFIG 8'h00

// reset values of the status flags and of the registered field copies
`define RST_JACK_CONDITION 2'h0
`define RST_HEADSET_VARIANT 2'h0
`define RST_MONITOR_CHANNEL 2'h2
`define RST_GENERATOR_CHANNEL 2'h2
`define RST_ACTIVITY_CLOCK_SOURCE 2'h0
`define RST_EXTERNAL_CLOCK_RATE 2'h0

// writable bit masks; all other bits are reserved and read zero
`define MASK_ACTIVITY_DETECT_CONFIG 8'hfa
`define MASK_SIGNAL_GEN_CONFIG 8'hc0
`define MASK_DETECT_GEN_CLOCK_CONFIG 8'hf4

// field positions
`define POS_JACK_CONDITION 6
`define POS_HEADSET_VARIANT 4
`define POS_ADC_POWER_POLICY 6
`define POS_MONITOR_CHANNEL 4
`define POS_DATA_OUT_IRQ_ENABLE 3
`define POS_DETECT_WHILE_RECORDING 1
`define POS_GENERATOR_CHANNEL 6
`define POS_ACTIVITY_CLOCK_SOURCE 6
`define POS_EXTERNAL_CLOCK_RATE 4
`define POS_PHASE_ONE_ENABLE 2

`endif

// File: hdl/activity_detect_pkg.sv
/*
 * Types for the activity-detect register slice.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package activity_detect_pkg;
	typedef enum logic [1:0] {
		JACK_NONE = 2'b00,
		JACK_NO_MIC = 2'b01,
		JACK_RESERVED = 2'b10,
		JACK_WITH_MIC = 2'b11
	} jack_condition_t;

	typedef enum logic [1:0] {
		HS_NOT_INSERTED = 2'b00,
		HS_MONO_RIGHT = 2'b01,
		HS_MONO_LEFT = 2'b10,
		HS_STEREO = 2'b11
	} headset_variant_t;

	typedef enum logic [1:0] {
		POWER_USER = 2'b00,
		POWER_IRQ_BOTH = 2'b01,
		POWER_IRQ_UP = 2'b10,
		POWER_FORBIDDEN = 2'b11
	} adc_power_policy_t;

	typedef enum logic [1:0] {
		CLK_INTERNAL_OSC = 2'b00,
		CLK_BIT_CLOCK = 2'b01,
		CLK_AUX_INPUT = 2'b10,
		CLK_CUSTOM = 2'b11
	} activity_clock_source_t;

	typedef enum logic [1:0] {
		RATE_24M576 = 2'b00,
		RATE_6M144 = 2'b01,
		RATE_12M288 = 2'b10,
		RATE_18M432 = 2'b11
	} external_clock_rate_t;

	// adc power sequencer states
	typedef enum logic [1:0] {
		ADC_OFF = 2'b00,
		ADC_ON = 2'b01
	} adc_state_t;
endpackage

// File: hdl/activity_detect_if.sv
/*
 * Interface carrying decoded configuration from the register file to the policy unit.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
interface activity_detect_if;
	import activity_detect_pkg::*;
	adc_power_policy_t policy;
	logic irq_enable;
	logic detect_while_recording;
	logic phase_one_enable;
	logic adc_on;
	logic detector_active;
	logic data_out_irq;
	modport regs (output policy, output irq_enable, output detect_while_recording,
		output phase_one_enable, input adc_on, input detector_active, input data_out_irq);
	modport policy_unit (input policy, input irq_enable, input detect_while_recording,
		input phase_one_enable, output adc_on, output detector_active, output data_out_irq);
endinterface

// File: hdl/adc_power_policy_unit.sv
/*
 * ADC auto power-up/power-down sequencer and serial data output interrupt steering.
 * Assumes activity and user commands are single-cycle pulses on the system clock.
 */
`timescale 1ns/1ps
module adc_power_policy_unit
	import activity_detect_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// activity detector and user commands
	input wire logic i_activity_event,
	input wire logic i_user_power_up,
	input wire logic i_user_power_down,
	// configuration and status
	activity_detect_if.policy_unit cfg
);
	adc_state_t state_reg;
	adc_state_t state_next;
	logic irq_level_reg;
	logic detect_ok;

	// detection suspended while recording unless enabled
	assign detect_ok = (state_reg == ADC_OFF) || cfg.detect_while_recording;

	// power sequencer; forbidden policy code behaves as user-only control
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ADC_OFF: begin
				if (i_user_power_up) begin
					state_next = ADC_ON;
				end else if (i_activity_event && detect_ok &&
					(cfg.policy == POWER_IRQ_BOTH || cfg.policy == POWER_IRQ_UP)) begin
					state_next = ADC_ON;
				end
			end
			ADC_ON: begin
				if (i_user_power_down) begin
					state_next = ADC_OFF;
				end else if (cfg.policy == POWER_IRQ_BOTH && i_activity_event && detect_ok) begin
					state_next = ADC_OFF;
				end
			end
			default: state_next = ADC_OFF;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_reg <= ADC_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// interrupt level on the data output pin, only while not recording
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			irq_level_reg <= 1'b0;
		end else begin
			irq_level_reg <= cfg.irq_enable && cfg.phase_one_enable && i_activity_event &&
				detect_ok && (state_reg == ADC_OFF);
		end
	end

	assign cfg.adc_on = (state_reg == ADC_ON);
	assign cfg.detector_active = cfg.phase_one_enable && detect_ok;
	assign cfg.data_out_irq = irq_level_reg;
endmodule

// File: dv/ctrl_host_model.sv
/* host model: drives the register port, one access at a time.
   assumes read data answers one cycle after the address edge. */
`timescale 1ns/1ps
module ctrl_host_model (
	// clock
	input wire logic i_clk,
	// register port
	output logic [7:0] o_reg_addr,
	output logic [7:0] o_reg_wdata,
	output logic o_reg_write,
	input wire logic [7:0] i_reg_rdata
);
	// idle port at time zero
	initial begin
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
		o_reg_write = 1'b0;
	end
	// strobe held over one edge; status low nibble always sent as zero
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_clk);
		#1;
		o_reg_addr = a;
		o_reg_wdata = (a == 8'h1c) ? (v & 8'hf0) : v;
		o_reg_write = 1'b1;
		@(posedge i_clk);
		#1;
		o_reg_write = 1'b0;
	endtask
	// address held until the answer is taken
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_clk);
		#1;
		o_reg_addr = a;
		@(posedge i_clk);
		#1;
		v = i_reg_rdata;
	endtask
endmodule

// File: dv/activity_detect_jack_status_regs_sva.sv
/* assertions on the register slice ports.
   assumes one clock domain and the bind below. */
`timescale 1ns/1ps
module activity_detect_jack_status_regs_sva (
	// clock, reset and register port
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_write,
	input wire logic [7:0] o_reg_rdata,
	// detection, commands and outputs
	input wire logic i_detect_done,
	input wire logic [1:0] i_jack_condition,
	input wire logic [1:0] i_headset_variant,
	input wire logic i_user_power_up,
	input wire logic i_serial_data_output,
	input wire logic o_serial_data_output,
	input wire logic o_adc_power_on,
	input wire logic [1:0] o_monitor_channel,
	input wire logic [1:0] o_generator_channel,
	input wire logic [1:0] o_activity_clock_source,
	input wire logic [1:0] o_external_clock_rate
);
	// single domain, synchronous reset
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	a_status_nibble: assert property ($past(i_reg_addr) == 8'h1c |-> o_reg_rdata[3:0] == 4'h0)
		else $error("status low nibble set");
	a_status_load: assert property (i_detect_done && i_reg_addr == 8'h1c ##1 i_reg_addr == 8'h1c
		|=> o_reg_rdata[7:4] == {$past(i_jack_condition, 2), $past(i_headset_variant, 2)})
		else $error("status flags wrong");
	a_cfg_readback: assert property (i_reg_write && i_reg_addr == 8'h1e ##1 i_reg_addr == 8'h1e
		|=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'hfa)) else $error("config readback wrong");
	a_monitor_field: assert property (i_reg_write && i_reg_addr == 8'h1e ##1 !i_reg_write
		|=> {2'h0, o_monitor_channel, 4'h0} == ($past(i_reg_wdata, 2) & 8'h30))
		else $error("monitor channel wrong");
	a_gen_field: assert property (i_reg_write && i_reg_addr == 8'h1f ##1 !i_reg_write
		|=> {o_generator_channel, 6'h00} == ($past(i_reg_wdata, 2) & 8'hc0))
		else $error("generator channel wrong");
	a_clock_fields: assert property (i_reg_write && i_reg_addr == 8'h20 ##1 !i_reg_write
		|=> {o_activity_clock_source, o_external_clock_rate, 4'h0} == ($past(i_reg_wdata, 2) & 8'hf0))
		else $error("clock fields wrong");
	a_pin_passthrough: assert property (o_adc_power_on && $past(o_adc_power_on) && $past(o_adc_power_on, 2)
		|-> o_serial_data_output == $past(i_serial_data_output)) else $error("pin not passing data");
	a_user_up: assert property (i_user_power_up |-> ##[1:3] o_adc_power_on)
		else $error("adc not powered by user");
endmodule
bind activity_detect_jack_status_regs activity_detect_jack_status_regs_sva sva_u (.*);

// File: dv/activity_detect_jack_status_regs_tb_top.sv
/* bench for the register slice: host model on the register port, tasks drive the rest.
   assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module activity_detect_jack_status_regs_tb_top;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d;
	logic i_reg_write, o_serial_data_output, o_adc_power_on, o_detector_active;
	logic i_detect_done = 1'b0, i_activity_event = 1'b0, i_serial_data_output = 1'b0;
	logic i_user_power_up = 1'b0, i_user_power_down = 1'b0;
	logic [1:0] i_jack_condition = 2'h0, i_headset_variant = 2'h0;
	logic [1:0] o_monitor_channel, o_generator_channel, o_activity_clock_source;
	logic [1:0] o_external_clock_rate;
	logic [7:0] ad [5] = '{8'h1c, 8'h1e, 8'h1f, 8'h20, 8'h1d};
	logic [7:0] rv [5] = '{8'h00, 8'h20, 8'h80, 8'h00, 8'h00};
	logic [7:0] mk [5] = '{8'h00, 8'hfa, 8'hc0, 8'hf4, 8'h00};
	int err_total = 0;
	int tests_run = 0;
	// 25 MHz clock
	always #20 i_clk = ~i_clk;
	// slice and host model
	activity_detect_jack_status_regs dut_u (.*);
	ctrl_host_model host_u (.i_clk(i_clk), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata),
		.o_reg_write(i_reg_write), .i_reg_rdata(o_reg_rdata));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic test_done;
		if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// reset values, then every two-bit code in every field, unmapped address last
	task automatic t_regs;
		for (int i = 0; i < 5; i++) begin
			host_u.rd(ad[i], d);
			chk(d, rv[i]);
		end
		for (int c = 0; c < 4; c++) begin
			for (int i = 0; i < 5; i++) begin
				host_u.wr(ad[i], {4{c[1:0]}});
				host_u.rd(ad[i], d);
				chk(d, mk[i] & {4{c[1:0]}});
			end
			chk({o_monitor_channel, o_generator_channel, o_activity_clock_source,
				o_external_clock_rate}, {4{c[1:0]}});
		end
	endtask
	// results load only on the strobe; inputs moved afterwards are ignored
	task automatic t_status;
		for (int k = 0; k < 16; k++) begin
			{i_jack_condition, i_headset_variant} = k[3:0];
			pulse(i_detect_done);
			{i_jack_condition, i_headset_variant} = ~k[3:0];
			host_u.rd(8'h1c, d);
			chk(d, {k[3:0], 4'h0});
		end
	endtask
	// two events under each usable policy, detection kept on while recording
	task automatic t_policy;
		host_u.wr(8'h20, 8'h04);
		for (int p = 0; p < 3; p++) begin
			pulse(i_user_power_down);
			host_u.wr(8'h1e, {p[1:0], 6'h02});
			pulse(i_activity_event);
			cyc(2);
			chk({6'h0, o_detector_active, o_adc_power_on}, {6'h0, 1'b1, p != 0});
			pulse(i_activity_event);
			cyc(2);
			chk({7'h0, o_adc_power_on}, {7'h0, p == 2});
		end
		host_u.wr(8'h1e, 8'h80);
		cyc(2);
		chk({7'h0, o_detector_active}, 8'h00);
		pulse(i_user_power_down);
		cyc(2);
		chk({7'h0, o_detector_active}, 8'h01);
		host_u.wr(8'h20, 8'h00);
		cyc(2);
		chk({7'h0, o_detector_active}, 8'h00);
		host_u.wr(8'h20, 8'h04);
	endtask
	// interrupt on the pin while idle, none while recording
	task automatic t_pin;
		pulse(i_user_power_down);
		host_u.wr(8'h1e, 8'h08);
		pulse(i_activity_event);
		cyc(1);
		chk({7'h0, o_serial_data_output}, 8'h01);
		pulse(i_user_power_up);
		pulse(i_activity_event);
		cyc(1);
		chk({7'h0, o_serial_data_output}, 8'h00);
		i_serial_data_output = 1'b1;
		cyc(2);
		chk({7'h0, o_serial_data_output}, 8'h01);
		i_serial_data_output = 1'b0;
	endtask
	// five reset cycles, then the scenarios
	initial begin
		cyc(5);
		i_sys_rst = 1'b0;
		t_regs;
		t_status;
		t_policy;
		t_pin;
		test_done;
	end
endmodule
